// file: design/iras_target.sv
`timescale 1ns/100ps
`default_nettype none

// Write buffer: array plus a registered output stage, so the data output is a flop.
// Depth must be a power of two; total capacity is DEPTH + 1 with the output stage.
module iras_fifo #(
    parameter int WIDTH = iras_pkg::FIFO_WIDTH,
    parameter int DEPTH = iras_pkg::FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push;
    wire load;
    wire [AW:0] next_count;

    // Output stage refills from a non-empty array whenever it is empty or being drained
    assign in_ready_out = count != (AW + 1)'(DEPTH);
    assign push = in_valid_in & in_ready_out;
    assign load = (count != '0) & (~out_valid_out | out_ready_in);
    assign next_count = count + (AW + 1)'(push) - (AW + 1)'(load);

    // Storage array, no reset needed
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    // Pointers, level and output stage
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            out_valid_out <= 1'h0;
            out_data_out <= '0;
        end else begin
            wr_ptr <= push ? wr_ptr + 1'h1 : wr_ptr;
            rd_ptr <= load ? rd_ptr + 1'h1 : rd_ptr;
            count <= next_count;
            out_valid_out <= load | (out_valid_out & ~out_ready_in);
            if (load) begin
                out_data_out <= mem[rd_ptr];
            end
        end
    end
endmodule

// Summary of operation
// - Host starts read with address, write direction
// - Acknowledge only own address, else ignore frame
// - Pointer byte acknowledged and loaded as address
// - Host repeated start, address with read direction
// - Send byte at pointer after read address
// - Host acknowledge increments pointer, next byte sent
// - Host nack then stop ends read, release
// - Write bytes acknowledged while the buffer has room (nack when full), stored at successive addresses
// - Respond to the fixed address only
// - Eight bits MSB first, then acknowledge slot
// - Data fall while clock high aborts transaction, except a start at bit count 0 or 1; a rise is a stop
module iras_target #(
    parameter logic [6:0] OWN_ADDR = iras_pkg::TARGET_ADDR,
    parameter int DEPTH = iras_pkg::FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    iras_if.dev link,
    output logic wr_valid_out,
    output logic [7:0] wr_addr_out,
    output logic [7:0] wr_data_out,
    input wire logic wr_ready_in,
    output logic [7:0] rd_addr_out,
    input wire logic [7:0] rd_data_in,
    output logic abort_out,
    output logic busy_out
);
    iras_pkg::iras_tgt_state_t state;
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic dir;
    logic acked;
    logic master_ack;
    logic sda_oe;
    wire scl_rise;
    wire scl_fall;
    wire sda_edge_hi;
    wire start_seen;
    wire stop_seen;
    wire rx_state;
    wire byte_done;
    wire addr_hit;
    wire fifo_ready;
    wire push;

    // Link pins pass two flops; only the second and the delayed copy feed logic
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
        end else begin
            {scl_m, scl_s, scl_d} <= {link.scl, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {link.sda, sda_m, sda_s};
        end
    end

    // Edge and condition decode on the synchronised lines
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign sda_edge_hi = scl_s & scl_d & (sda_s ^ sda_d);
    assign start_seen = sda_edge_hi & ~sda_s;
    assign stop_seen = sda_edge_hi & sda_s;
    assign rx_state = (state == iras_pkg::TS_ADDR) | (state == iras_pkg::TS_PTR) | (state == iras_pkg::TS_WR);
    assign byte_done = scl_fall & (bit_cnt == iras_pkg::ACK_SLOT);
    assign addr_hit = shift[7:1] == OWN_ADDR;
    assign push = (state == iras_pkg::TS_WR) & byte_done & fifo_ready;

    // Open drain: the output level is always low, only the enable moves
    assign link.sda_d_out = 1'h0;
    assign link.sda_d_oe = sda_oe;

    // Each stored byte carries the register address it was written to
    iras_fifo #(.WIDTH(iras_pkg::FIFO_WIDTH), .DEPTH(DEPTH)) u_wr_fifo (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .in_valid_in(push),
        .in_data_in({rd_addr_out, shift}),
        .in_ready_out(fifo_ready),
        .out_valid_out(wr_valid_out),
        .out_data_out({wr_addr_out, wr_data_out}),
        .out_ready_in(wr_ready_in)
    );

    // Protocol engine; data changes only after a falling clock edge is seen.
    // A repeated start lands after the first bit's rise was counted, so counts 0 and 1 both take it.
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            state <= iras_pkg::TS_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            dir <= iras_pkg::DIR_WRITE;
            acked <= 1'h0;
            master_ack <= 1'h0;
            sda_oe <= 1'h0;
            rd_addr_out <= 8'h00;
            abort_out <= 1'h0;
            busy_out <= 1'h0;
        end else begin
            abort_out <= 1'h0;
            busy_out <= state != iras_pkg::TS_IDLE;
            if (stop_seen) begin
                state <= iras_pkg::TS_IDLE;
                sda_oe <= 1'h0;
            end else if (start_seen & ((bit_cnt <= 4'h1) | (state == iras_pkg::TS_IDLE))) begin
                state <= iras_pkg::TS_ADDR;
                bit_cnt <= 4'h0;
                sda_oe <= 1'h0;
            end else if (sda_edge_hi & (state != iras_pkg::TS_IDLE)) begin
                state <= iras_pkg::TS_IDLE;
                sda_oe <= 1'h0;
                abort_out <= 1'h1;
            end else begin
                // Receive side samples while the clock is high, MSB first
                if (scl_rise & rx_state) begin
                    shift <= {shift[6:0], sda_s};
                end
                if (scl_rise & (rx_state | (state == iras_pkg::TS_RD))) begin
                    bit_cnt <= bit_cnt + 4'h1;
                end
                case (state)
                    iras_pkg::TS_ADDR: begin
                        if (byte_done) begin
                            bit_cnt <= 4'h0;
                            dir <= shift[0];
                            sda_oe <= addr_hit;
                            state <= addr_hit ? iras_pkg::TS_ADDR_ACK : iras_pkg::TS_IDLE;
                        end
                    end
                    iras_pkg::TS_PTR: begin
                        if (byte_done) begin
                            bit_cnt <= 4'h0;
                            rd_addr_out <= shift;
                            sda_oe <= 1'h1;
                            state <= iras_pkg::TS_PTR_ACK;
                        end
                    end
                    iras_pkg::TS_WR: begin
                        if (byte_done) begin
                            // A full buffer refuses the byte with a nack
                            bit_cnt <= 4'h0;
                            acked <= fifo_ready;
                            sda_oe <= fifo_ready;
                            state <= iras_pkg::TS_WR_ACK;
                        end
                    end
                    iras_pkg::TS_ADDR_ACK: begin
                        if (scl_fall & (dir == iras_pkg::DIR_READ)) begin
                            sda_oe <= ~rd_data_in[7];
                            shift <= {rd_data_in[6:0], 1'h0};
                            state <= iras_pkg::TS_RD;
                        end else if (scl_fall) begin
                            sda_oe <= 1'h0;
                            state <= iras_pkg::TS_PTR;
                        end
                    end
                    iras_pkg::TS_PTR_ACK: begin
                        if (scl_fall) begin
                            sda_oe <= 1'h0;
                            state <= iras_pkg::TS_WR;
                        end
                    end
                    iras_pkg::TS_WR_ACK: begin
                        if (scl_fall) begin
                            sda_oe <= 1'h0;
                            rd_addr_out <= acked ? rd_addr_out + 8'h01 : rd_addr_out;
                            state <= acked ? iras_pkg::TS_WR : iras_pkg::TS_IDLE;
                        end
                    end
                    iras_pkg::TS_RD: begin
                        if (byte_done) begin
                            bit_cnt <= 4'h0;
                            sda_oe <= 1'h0;
                            state <= iras_pkg::TS_RD_ACK;
                        end else if (scl_fall) begin
                            sda_oe <= ~shift[7];
                            shift <= {shift[6:0], 1'h0};
                        end
                    end
                    iras_pkg::TS_RD_ACK: begin
                        if (scl_rise) begin
                            master_ack <= ~sda_s;
                            rd_addr_out <= sda_s ? rd_addr_out : rd_addr_out + 8'h01;
                        end else if (scl_fall & master_ack) begin
                            sda_oe <= ~rd_data_in[7];
                            shift <= {rd_data_in[6:0], 1'h0};
                            state <= iras_pkg::TS_RD;
                        end else if (scl_fall) begin
                            state <= iras_pkg::TS_IDLE;
                        end
                    end
                    default: begin
                        bit_cnt <= 4'h0;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// file: design/iras_pkg.sv
package iras_pkg;
    // Fixed target address on the two-wire link
    localparam logic [6:0] TARGET_ADDR = 7'h7E;
    localparam logic DIR_WRITE = 1'h0;
    localparam logic DIR_READ = 1'h1;
    // Bit slot that carries the acknowledge after eight data bits
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 16;
    // Host clock generation: one link bit is four quarters
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_QUARTER_NS = 50;
    localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        TS_IDLE = 4'h0,
        TS_ADDR = 4'h1,
        TS_ADDR_ACK = 4'h2,
        TS_PTR = 4'h3,
        TS_PTR_ACK = 4'h4,
        TS_WR = 4'h5,
        TS_WR_ACK = 4'h6,
        TS_RD = 4'h7,
        TS_RD_ACK = 4'h8
    } iras_tgt_state_t;

    typedef enum logic [3:0] {
        HS_IDLE = 4'h0,
        HS_START = 4'h1,
        HS_ADDR_W = 4'h2,
        HS_PTR = 4'h3,
        HS_WDATA = 4'h4,
        HS_RESTART = 4'h5,
        HS_ADDR_R = 4'h6,
        HS_RDATA = 4'h7,
        HS_STOP = 4'h8
    } iras_host_state_t;
endpackage

// file: design/iras_if.sv
`timescale 1ns/100ps
`default_nettype none
interface iras_if;
    logic scl;
    logic sda_h_out;
    logic sda_h_oe;
    logic sda_d_out;
    logic sda_d_oe;
    wire logic sda;

    // Open-drain data line with pull-up: any enabled low driver wins
    assign sda = ~((sda_h_oe & ~sda_h_out) | (sda_d_oe & ~sda_d_out));

    modport host (output scl, output sda_h_out, output sda_h_oe, input sda);
    modport dev (input scl, input sda, output sda_d_out, output sda_d_oe);
endinterface
`default_nettype wire

// file: design/iras_host.sv
`timescale 1ns/100ps
`default_nettype none

// Link master: one command is a single-byte write or a read of 1..15 bytes
module iras_host #(
    parameter logic [6:0] TGT_ADDR = iras_pkg::TARGET_ADDR,
    parameter int QUARTER_CYC = iras_pkg::SCL_QUARTER_CYC
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    iras_if.host link,
    input wire logic cmd_valid_in,
    output logic cmd_ready_out,
    input wire logic cmd_read_in,
    input wire logic [7:0] cmd_ptr_in,
    input wire logic [7:0] cmd_wdata_in,
    input wire logic [3:0] cmd_count_in,
    output logic rd_valid_out,
    output logic [7:0] rd_data_out,
    output logic done_out,
    output logic nack_out
);
    iras_pkg::iras_host_state_t state;
    iras_pkg::iras_host_state_t after_ack;
    logic sda_m;
    logic sda_s;
    logic [7:0] qcnt;
    logic [1:0] q;
    logic [3:0] bit_idx;
    logic [7:0] shift;
    logic [3:0] remain;
    logic is_read;
    logic [7:0] ptr;
    logic [7:0] wdata;
    logic scl_drive;
    logic sda_pull;
    wire tick;
    wire slot_end;
    wire ack_slot;
    wire last;
    wire tx_st;
    wire cond_st;
    wire lvl_a;
    wire lvl_b;

    // Quarter timing; a slot is low, low, high, high
    assign tick = qcnt == 8'(QUARTER_CYC - 1);
    assign slot_end = tick & (q == 2'h3);
    assign ack_slot = bit_idx == iras_pkg::ACK_SLOT;
    assign last = remain == 4'h1;
    assign tx_st = (state == iras_pkg::HS_ADDR_W) | (state == iras_pkg::HS_PTR) |
                   (state == iras_pkg::HS_WDATA) | (state == iras_pkg::HS_ADDR_R);
    assign cond_st = (state == iras_pkg::HS_START) | (state == iras_pkg::HS_RESTART);
    // Line level for the first three quarters, then for the last one
    assign lvl_a = cond_st ? 1'h1 : (state == iras_pkg::HS_STOP) ? 1'h0 :
                   tx_st ? (ack_slot | shift[7]) : (state == iras_pkg::HS_RDATA) ? (~ack_slot | last) : 1'h1;
    assign lvl_b = cond_st ? 1'h0 : (state == iras_pkg::HS_STOP) ? 1'h1 : lvl_a;
    assign after_ack = (state == iras_pkg::HS_ADDR_W) ? iras_pkg::HS_PTR :
                       (state == iras_pkg::HS_PTR) ? (is_read ? iras_pkg::HS_RESTART : iras_pkg::HS_WDATA) :
                       (state == iras_pkg::HS_ADDR_R) ? iras_pkg::HS_RDATA : iras_pkg::HS_STOP;

    assign link.scl = scl_drive;
    assign link.sda_h_out = 1'h0;
    assign link.sda_h_oe = sda_pull;

    // Data line from the pin passes two flops
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            {sda_m, sda_s} <= 2'h3;
        end else begin
            {sda_m, sda_s} <= {link.sda, sda_m};
        end
    end

    // Command sequencer; a nack anywhere goes straight to the stop slot
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            state <= iras_pkg::HS_IDLE;
            qcnt <= 8'h00;
            q <= 2'h0;
            bit_idx <= 4'h0;
            shift <= 8'h00;
            remain <= 4'h0;
            is_read <= 1'h0;
            ptr <= 8'h00;
            wdata <= 8'h00;
            cmd_ready_out <= 1'h1;
            rd_valid_out <= 1'h0;
            rd_data_out <= 8'h00;
            done_out <= 1'h0;
            nack_out <= 1'h0;
            scl_drive <= 1'h1;
            sda_pull <= 1'h0;
        end else begin
            rd_valid_out <= 1'h0;
            done_out <= 1'h0;
            scl_drive <= (state == iras_pkg::HS_IDLE) | q[1];
            sda_pull <= (state != iras_pkg::HS_IDLE) & ~((q == 2'h3) ? lvl_b : lvl_a);
            if (state == iras_pkg::HS_IDLE) begin
                qcnt <= 8'h00;
                q <= 2'h0;
                if (cmd_valid_in & cmd_ready_out) begin
                    state <= iras_pkg::HS_START;
                    cmd_ready_out <= 1'h0;
                    nack_out <= 1'h0;
                    is_read <= cmd_read_in;
                    ptr <= cmd_ptr_in;
                    wdata <= cmd_wdata_in;
                    remain <= (cmd_count_in == 4'h0) ? 4'h1 : cmd_count_in;
                end
            end else begin
                qcnt <= tick ? 8'h00 : qcnt + 8'h01;
                q <= tick ? q + 2'h1 : q;
                if (slot_end) begin
                    case (state)
                        iras_pkg::HS_START: begin
                            state <= iras_pkg::HS_ADDR_W;
                            shift <= {TGT_ADDR, iras_pkg::DIR_WRITE};
                            bit_idx <= 4'h0;
                        end
                        iras_pkg::HS_RESTART: begin
                            state <= iras_pkg::HS_ADDR_R;
                            shift <= {TGT_ADDR, iras_pkg::DIR_READ};
                            bit_idx <= 4'h0;
                        end
                        iras_pkg::HS_ADDR_W, iras_pkg::HS_PTR, iras_pkg::HS_WDATA, iras_pkg::HS_ADDR_R: begin
                            if (!ack_slot) begin
                                shift <= {shift[6:0], 1'h0};
                                bit_idx <= bit_idx + 4'h1;
                            end else begin
                                bit_idx <= 4'h0;
                                nack_out <= sda_s;
                                state <= sda_s ? iras_pkg::HS_STOP : after_ack;
                                shift <= (state == iras_pkg::HS_ADDR_W) ? ptr : wdata;
                            end
                        end
                        iras_pkg::HS_RDATA: begin
                            if (!ack_slot) begin
                                shift <= {shift[6:0], sda_s};
                                bit_idx <= bit_idx + 4'h1;
                            end else begin
                                bit_idx <= 4'h0;
                                rd_valid_out <= 1'h1;
                                rd_data_out <= shift;
                                remain <= remain - 4'h1;
                                state <= last ? iras_pkg::HS_STOP : iras_pkg::HS_RDATA;
                            end
                        end
                        iras_pkg::HS_STOP: begin
                            state <= iras_pkg::HS_IDLE;
                            done_out <= 1'h1;
                            cmd_ready_out <= 1'h1;
                        end
                        default: begin
                            state <= iras_pkg::HS_IDLE;
                        end
                    endcase
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/iras_properties.sv
`timescale 1ns/100ps
`default_nettype none
module iras_properties (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_h_oe,
    input wire logic sda_d_oe
);
    logic p_scl;
    logic p_sda;
    logic rd;
    logic [1:0] nbyte;
    logic [3:0] bits;
    logic [7:0] sh;
    // Edges seen from the sampled wire, not from either end's state
    wire logic rise_w = scl & ~p_scl;
    wire logic start_w = scl & p_scl & p_sda & ~sda;
    wire logic ack9_w = rise_w & (bits == 4'h8);
    // Frame tracker: bit slot, byte number and direction bit
    always_ff @(posedge clk_in) begin
        p_scl <= scl;
        p_sda <= sda;
        if (!resetn_in || start_w) begin
            bits <= 4'h0;
            nbyte <= 2'h0;
            rd <= 1'h0;
        end else if (rise_w) begin
            bits <= (bits == 4'h8) ? 4'h0 : bits + 4'h1;
            sh <= (bits == 4'h8) ? sh : {sh[6:0], sda};
            if (bits == 4'h8 && nbyte != 2'h3) nbyte <= nbyte + 2'h1;
            if (bits == 4'h8 && nbyte == 2'h0) rd <= sh[0];
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    sequence addr_s;
        ack9_w ##0 (nbyte == 2'h0 && sh[7:1] == iras_pkg::TARGET_ADDR);
    endsequence
    sequence host_nack_s;
        ack9_w ##0 (rd && nbyte != 2'h0 && sda);
    endsequence
    scl_high_a: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high phase too short");
    tgt_still_a: assert property (scl && p_scl |-> $stable(sda_d_oe))
        else $error("target moved data while clock high");
    only_host_a: assert property (scl && p_scl && sda != p_sda |-> $changed(sda_h_oe))
        else $error("data changed under high clock without host");
    tgt_low_a: assert property ($rose(sda_d_oe) |-> !scl && !sda_h_oe)
        else $error("target drive began outside low phase");
    addr_ack_a: assert property (addr_s |-> !sda)
        else $error("own address not acknowledged");
    ptr_ack_a: assert property (ack9_w && nbyte == 2'h1 && !rd |-> !sda)
        else $error("pointer byte not acknowledged");
    rd_only_a: assert property (rise_w && bits != 4'h8 && sda_d_oe |-> rd && nbyte != 2'h0)
        else $error("target drove data outside read phase");
    nack_rel_a: assert property (host_nack_s |=> !sda_d_oe [*8])
        else $error("target kept driving after final nack");
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
    typedef struct packed {logic rd; logic [7:0] ptr; logic [7:0] wd; logic [3:0] n; logic nk;} iras_row_t;
    logic clk_in = 1'h0;
    logic resetn_in = 1'h0;
    logic cmd_valid = 1'h0;
    logic cmd_read = 1'h0;
    logic [7:0] cmd_ptr = 8'h00;
    logic [7:0] cmd_wdata = 8'h00;
    logic [3:0] cmd_count = 4'h0;
    logic wr_ready = 1'h1;
    logic cmd_ready, rd_valid, done, nack, wr_valid, abort1, abort2, busy;
    logic [7:0] rd_data, wr_addr, wr_data, rd_addr;
    logic [7:0] mem [256];
    logic [15:0] wq [$];
    logic [15:0] wexp;
    logic ab1 = 1'h0;
    logic ab2 = 1'h0;
    int bad_count = 0;
    int num_checks = 0;
    wire logic [7:0] rd_word = mem[rd_addr];
    wire logic [15:0] wr_word = {wr_addr, wr_data};
    iras_row_t rows [5] = '{'{1'h0, 8'h10, 8'h3C, 4'h0, 1'h0}, '{1'h0, 8'hFF, 8'hC3, 4'h0, 1'h0},
        '{1'h1, 8'h10, 8'h00, 4'h0, 1'h0}, '{1'h1, 8'hFE, 8'h00, 4'h3, 1'h0},
        '{1'h1, 8'hF8, 8'h00, 4'hF, 1'h0}};
    logic [6:0] addrs [4] = '{7'h7F, 7'h3E, 7'h7C, 7'h7E};
    iras_if lk();
    iras_if lk2();
    // Main link joins the two ends; second link is bit-banged to break rules
    iras_host iras_host_inst (.clk_in(clk_in), .resetn_in(resetn_in), .link(lk.host),
        .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_read_in(cmd_read),
        .cmd_ptr_in(cmd_ptr), .cmd_wdata_in(cmd_wdata), .cmd_count_in(cmd_count),
        .rd_valid_out(rd_valid), .rd_data_out(rd_data), .done_out(done), .nack_out(nack));
    iras_target iras_target_inst (.clk_in(clk_in), .resetn_in(resetn_in), .link(lk.dev),
        .wr_valid_out(wr_valid), .wr_addr_out(wr_addr), .wr_data_out(wr_data), .wr_ready_in(wr_ready),
        .rd_addr_out(rd_addr), .rd_data_in(rd_word), .abort_out(abort1), .busy_out(busy));
    iras_target iras_target_inst2 (.clk_in(clk_in), .resetn_in(resetn_in), .link(lk2.dev),
        .wr_valid_out(), .wr_addr_out(), .wr_data_out(), .wr_ready_in(1'h1),
        .rd_addr_out(), .rd_data_in(8'h00), .abort_out(abort2), .busy_out());
    iras_properties iras_properties_inst (.clk_in(clk_in), .resetn_in(resetn_in), .scl(lk.scl),
        .sda(lk.sda), .sda_h_oe(lk.sda_h_oe), .sda_d_oe(lk.sda_d_oe));
    always #5 clk_in = ~clk_in;
    // Abort pulses are one cycle wide, so keep a sticky copy
    always @(posedge clk_in) begin
        if (abort1 === 1'h1) ab1 <= 1'h1;
        if (abort2 === 1'h1) ab2 <= 1'h1;
    end
    // Popped writes must match issue order; they also update the register image
    always @(negedge clk_in) begin
        if (wr_valid === 1'h1 && wr_ready === 1'h1) begin
            wexp = wq.pop_front();
            `CHK("wr", wexp, wr_word)
            mem[wr_addr] = wr_data;
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // One host command; read bytes are checked against the register image in order
    task automatic run_cmd(input iras_row_t r);
        int t;
        int k;
        logic [7:0] a;
        a = r.ptr;
        k = 0;
        @(posedge clk_in);
        cmd_valid <= 1'h1;
        cmd_read <= r.rd;
        cmd_ptr <= r.ptr;
        cmd_wdata <= r.wd;
        cmd_count <= r.n;
        if (!r.rd && !r.nk) wq.push_back({r.ptr, r.wd});
        @(posedge clk_in);
        cmd_valid <= 1'h0;
        for (t = 0; t < 5000 && done !== 1'h1; t++) begin
            @(negedge clk_in);
            if (rd_valid === 1'h1) begin
                `CHK("rd", mem[a], rd_data)
                a++;
                k++;
            end
        end
        `CHK("done", 1'h1, done)
        `CHK("cnt", r.rd ? ((r.n == 4'h0) ? 1 : int'(r.n)) : 0, k)
        `CHK("nack", r.nk, nack)
    endtask
    // Bench acts as a rule-breaking host on the second link
    task automatic bb(input logic c, input logic d);
        @(posedge clk_in);
        lk2.scl <= c;
        lk2.sda_h_oe <= ~d;
        repeat (5) @(posedge clk_in);
    endtask
    task automatic bframe(input logic [6:0] ad, input logic brk, output logic ack);
        bb(1'h1, 1'h1);
        bb(1'h1, 1'h0);
        for (int i = 7; i >= 0; i--) begin
            bb(1'h0, (i == 0) ? 1'h0 : ad[i-1]);
            bb(1'h1, (i == 0) ? 1'h0 : ad[i-1]);
        end
        bb(1'h0, 1'h1);
        bb(1'h1, 1'h1);
        ack = ~lk2.sda;
        if (brk) begin
            // Two pointer bits first: a fall in the first bit's high phase is a legal restart
            bb(1'h0, 1'h1);
            bb(1'h1, 1'h1);
            bb(1'h0, 1'h1);
            bb(1'h1, 1'h1);
            bb(1'h1, 1'h0);
        end
        bb(1'h0, 1'h0);
        bb(1'h1, 1'h0);
        bb(1'h1, 1'h1);
    endtask
    initial begin
        logic ack;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
        lk2.scl = 1'h1;
        lk2.sda_h_oe = 1'h0;
        lk2.sda_h_out = 1'h0;
        repeat (8) @(posedge clk_in);
        resetn_in <= 1'h1;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        `CHK("ready", 1'h1, cmd_ready)
        `CHK("ptr0", 8'h00, rd_addr)
        `CHK("busy", 1'h0, busy)
        `CHK("sda", 1'h1, lk.sda)
        foreach (rows[i]) run_cmd(rows[i]);
        // Fill the write buffer with the user stalled; the tenth byte is refused
        @(posedge clk_in);
        wr_ready <= 1'h0;
        for (int i = 0; i < 10; i++) run_cmd('{1'h0, 8'h40 + 8'(i), 8'h80 + 8'(i), 4'h0, i == 9});
        `CHK("full", 1'h1, wr_valid)
        for (int t = 0; t < 60 && wq.size() != 0; t++) begin
            @(posedge clk_in);
            wr_ready <= ~wr_ready;
        end
        @(posedge clk_in);
        wr_ready <= 1'h1;
        @(negedge clk_in);
        `CHK("left", 0, wq.size())
        `CHK("empty", 1'h0, wr_valid)
        run_cmd('{1'h1, 8'h47, 8'h00, 4'h3, 1'h0});
        `CHK("ptr", 8'h49, rd_addr)
        foreach (addrs[i]) begin
            bframe(addrs[i], 1'h0, ack);
            `CHK("ack2", addrs[i] == iras_pkg::TARGET_ADDR, ack)
        end
        `CHK("noabort", 1'h0, ab2)
        bframe(iras_pkg::TARGET_ADDR, 1'h1, ack);
        `CHK("abort", 1'h1, ab2)
        `CHK("abort1", 1'h0, ab1)
        // Reset in mid-run must clear the pointer that the reads moved
        @(posedge clk_in);
        resetn_in <= 1'h0;
        repeat (8) @(posedge clk_in);
        resetn_in <= 1'h1;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        `CHK("ptr_rst", 8'h00, rd_addr)
        `CHK("busy_rst", 1'h0, busy)
        `CHK("ready_rst", 1'h1, cmd_ready)
        stop_test();
    end
    // Watchdog well beyond the expected run of about 14000 cycles
    initial begin
        repeat (60000) @(posedge clk_in);
        bad_count++;
        stop_test();
    end
endmodule
`default_nettype wire
